// ==== logic/pioc_output_control.sv ====
// Purpose: Output control words, second output stage and base control word.
// Assumes: Host port is a 16-bit synchronous strobe port on the bus clock.
// Notes:   DIFF_PAIRS picks the build variant: 0, 4, 8, 12, 16, 20 or 24.
`timescale 1ns/100ps
`default_nettype none
module pioc_output_control #(
  parameter int DIFF_PAIRS = 0
) (
  input  wire logic                          clock,          // Bus clock, 20 MHz.
  input  wire logic                          rst_n,          // Synchronous reset, active low.
  input  wire logic [pioc_pkg::ADDR_W-1:0]   reg_addr,       // Byte offset of the access.
  input  wire logic                          reg_wr,         // Write strobe, one cycle.
  input  wire logic                          reg_rd,         // Read strobe, one cycle.
  input  wire logic [pioc_pkg::WORD_W-1:0]   reg_wdata,      // Write data.
  output logic      [pioc_pkg::WORD_W-1:0]   reg_rdata,      // Read data.
  output logic                               reg_ack,        // Access done, one cycle.
  input  wire logic [pioc_pkg::CNT_W-1:0]    preload_value,  // Down-counter preload.
  input  wire logic [pioc_pkg::CNT_W-1:0]    mask_value,     // Up-counter period mask.
  input  wire logic                          filt_int_req,   // Filtered-input interrupt.
  output logic      [pioc_pkg::NUM_LINES-1:0] se_drive_low,  // Open-drain enable per line.
  output logic      [pioc_pkg::MAX_PAIRS-1:0] diff_data,     // Pair data value.
  output logic      [pioc_pkg::MAX_PAIRS-1:0] diff_tx_en,    // Pair transmit enable.
  output logic                               int_req,        // Level-0 interrupt, high.
  output logic      [pioc_pkg::CNT_W-1:0]    up_readback     // Up-counter readback.
);
  import pioc_pkg::*;

  localparam int SE_LINES = NUM_LINES - 2 * DIFF_PAIRS;
  localparam int DATA_LO  = NUM_LINES - 2 * DIFF_PAIRS;
  localparam int DIR_LO   = NUM_LINES - DIFF_PAIRS;
  // Highest data position: line 47 when single-ended, else the top pair data bit.
  localparam int SQ_POS   = (DIFF_PAIRS == 0) ? NUM_LINES - 1 : DIR_LO - 1;
  // Guarded indices keep the variant checks in range when there are no pairs.
  localparam int DIR0     = (DIFF_PAIRS > 0) ? DIR_LO : 0;
  localparam int TOP_DATA = (DIFF_PAIRS > 0) ? DIFF_PAIRS - 1 : 0;

  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic [NUM_LINES-1:0] ctrl_reg;
  logic [NUM_LINES-1:0] ctrl_next;
  logic [NUM_LINES-1:0] stage2_reg;
  logic [NUM_LINES-1:0] stage2_next;
  logic [WORD_W-1:0]    base_reg;
  logic [WORD_W-1:0]    base_next;
  logic [WORD_W-1:0]    rdata_reg;
  logic [WORD_W-1:0]    rdata_next;
  logic                 ack_reg;
  logic                 ack_next;
  logic                 released_reg;
  logic                 released_next;
  logic                 int_reg;
  logic                 int_next;
  logic [NUM_LINES-1:0] se_reg;
  logic [NUM_LINES-1:0] se_next;
  logic [MAX_PAIRS-1:0] dd_reg;
  logic [MAX_PAIRS-1:0] dd_next;
  logic [MAX_PAIRS-1:0] tx_reg;
  logic [MAX_PAIRS-1:0] tx_next;
  logic [NUM_LINES-1:0] eff;
  logic                 down_zero;
  logic                 down_wave;
  logic                 up_event;

  // Host register port: primary control words and base word.
  always_comb begin
    ctrl_next  = ctrl_reg;
    base_next  = base_reg;
    rdata_next = rdata_reg;
    ack_next   = reg_wr | reg_rd;
    if (reg_wr) begin
      if (hit(reg_addr, OFS_CTRL_LOW)) begin
        ctrl_next[15:0] = reg_wdata;
      end
      if (hit(reg_addr, OFS_CTRL_MID)) begin
        ctrl_next[31:16] = reg_wdata;
      end
      if (hit(reg_addr, OFS_CTRL_HIGH)) begin
        ctrl_next[47:32] = reg_wdata;
      end
      if (hit(reg_addr, OFS_BASE)) begin
        base_next = reg_wdata;
      end
    end
    if (reg_rd) begin
      unique case (1'b1)
        hit(reg_addr, OFS_CTRL_LOW):  rdata_next = ctrl_reg[15:0];
        hit(reg_addr, OFS_CTRL_MID):  rdata_next = ctrl_reg[31:16];
        hit(reg_addr, OFS_CTRL_HIGH): rdata_next = ctrl_reg[47:32];
        hit(reg_addr, OFS_BASE):      rdata_next = base_reg;
        default:                      rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg  <= {CTRL_RESET, CTRL_RESET, CTRL_RESET};
      base_reg  <= BASE_RESET;
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      base_reg  <= base_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  // Second output stage. Copying every clock while enabled gives both the
  // per-word update one clock after a write and the joint update on enable.
  always_comb begin
    stage2_next   = base_reg[BIT_OUT_REG_EN] ? ctrl_reg : stage2_reg;
    released_next = released_reg | base_reg[BIT_OUT_REG_EN];
    eff           = stage2_next;
    if (base_reg[BIT_SQUARE_WAVE]) begin
      eff[SQ_POS] = down_wave;
    end
  end

  // Line mapping. Until the stage is first enabled every driver stays off.
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_se
    if (i < SE_LINES) begin : g_on
      assign se_next[i] = released_next & ~eff[i];
    end else begin : g_off
      assign se_next[i] = 1'b0;
    end
  end

  for (genvar k = 0; k < MAX_PAIRS; k++) begin : g_pair
    if (k < DIFF_PAIRS) begin : g_on
      assign dd_next[k] = eff[DATA_LO + k];
      assign tx_next[k] = released_next & eff[DIR_LO + k];
    end else begin : g_off
      assign dd_next[k] = 1'b0;
      assign tx_next[k] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage2_reg   <= {CTRL_RESET, CTRL_RESET, CTRL_RESET};
      released_reg <= 1'b0;
      se_reg       <= '0;
      dd_reg       <= '0;
      tx_reg       <= '0;
    end else begin
      stage2_reg   <= stage2_next;
      released_reg <= released_next;
      se_reg       <= se_next;
      dd_reg       <= dd_next;
      tx_reg       <= tx_next;
    end
  end

  // Interrupt request, gated by the master enable.
  always_comb begin
    int_next = base_reg[BIT_MASTER_INT] &
               (filt_int_req |
                base_reg[BIT_FORCE_INT] |
                (base_reg[BIT_DOWN_INT_EN] & down_zero) |
                (base_reg[BIT_UP_INT_EN] & up_event));
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= int_next;
    end
  end

  pioc_down_counter u_down (
    .clock      (clock),
    .rst_n      (rst_n),
    .load       (base_reg[BIT_DOWN_LOAD]),
    .preload    (preload_value),
    .zero_pulse (down_zero),
    .wave       (down_wave)
  );

  pioc_up_counter u_up (
    .clock       (clock),
    .rst_n       (rst_n),
    .clear       (base_reg[BIT_UP_CLEAR]),
    .hold        (base_reg[BIT_UP_HOLD]),
    .mask        (mask_value),
    .event_pulse (up_event),
    .readback    (up_readback)
  );

  assign reg_rdata    = rdata_reg;
  assign reg_ack      = ack_reg;
  assign se_drive_low = se_reg;
  assign diff_data    = dd_reg;
  assign diff_tx_en   = tx_reg;
  assign int_req      = int_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_stage_holds: assert property (!base_reg[BIT_OUT_REG_EN] |=> $stable(stage2_reg))
    else $error("Output stage changed while the output register control was low.");
  a_word_passes: assert property (
    (reg_wr && hit(reg_addr, OFS_CTRL_LOW) && base_reg[BIT_OUT_REG_EN])
      ##1 base_reg[BIT_OUT_REG_EN] |=> stage2_reg[15:0] == $past(reg_wdata, 2))
    else $error("Written low control word did not reach the output stage.");
  a_sync_update: assert property ($rose(base_reg[BIT_OUT_REG_EN]) |-> ##1 stage2_reg == $past(ctrl_reg))
    else $error("Enabling the output stage did not move all words together.");
  a_master_gates: assert property (!base_reg[BIT_MASTER_INT] |=> !int_req)
    else $error("Interrupt raised without master enable.");
  a_force_raises: assert property (
    (base_reg[BIT_MASTER_INT] && base_reg[BIT_FORCE_INT]) |=> int_req)
    else $error("Forced interrupt did not assert.");
  a_down_int: assert property (
    (base_reg[BIT_MASTER_INT] && base_reg[BIT_DOWN_INT_EN] && down_zero) |=> int_req)
    else $error("Down-counter zero did not interrupt.");
  a_pair_tx: assert property (
    (released_reg && DIFF_PAIRS > 0 && !base_reg[BIT_SQUARE_WAVE])
      |=> diff_tx_en[0] == $past(stage2_next[DIR0]))
    else $error("Pair transmit enable does not follow its direction bit.");
  a_base_readback: assert property (
    (reg_wr && hit(reg_addr, OFS_BASE)) ##1 !reg_wr
      ##1 (reg_rd && hit(reg_addr, OFS_BASE) && !reg_wr) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("Base control word did not read back its written value.");
  a_reset_off: assert property (disable iff (1'b0)
    !rst_n |=> se_drive_low == '0 && diff_tx_en == '0 && !int_req)
    else $error("Drivers not off after reset.");

  // Line drivers stay quiet before release and outside the variant's range.
  a_idle_until_release: assert property (
    !released_reg |-> se_drive_low == '0 && diff_tx_en == '0)
    else $error("Drivers or transmit enables on before the output stage was released.");
  a_unused_lines: assert property ((se_drive_low >> SE_LINES) == '0)
    else $error("Open-drain enable set on a line owned by a differential pair.");
  a_diff_unused: assert property (
    (diff_tx_en >> DIFF_PAIRS) == '0 && (diff_data >> DIFF_PAIRS) == '0)
    else $error("Pair output active beyond the pairs of this variant.");
  a_mid_passes: assert property (
    (reg_wr && hit(reg_addr, OFS_CTRL_MID) && base_reg[BIT_OUT_REG_EN])
      ##1 base_reg[BIT_OUT_REG_EN] |=> stage2_reg[31:16] == $past(reg_wdata, 2))
    else $error("Written mid control word did not reach the output stage.");
  a_high_passes: assert property (
    (reg_wr && hit(reg_addr, OFS_CTRL_HIGH) && base_reg[BIT_OUT_REG_EN])
      ##1 base_reg[BIT_OUT_REG_EN] |=> stage2_reg[47:32] == $past(reg_wdata, 2))
    else $error("Written high control word did not reach the output stage.");
  a_wave_on_top: assert property (
    (released_reg && base_reg[BIT_SQUARE_WAVE]) |=> ((DIFF_PAIRS == 0) ?
      (se_drive_low[NUM_LINES-1] == !$past(down_wave)) :
      (diff_data[TOP_DATA] == $past(down_wave))))
    else $error("Square wave is not on the highest output position.");
  a_force_clears: assert property (
    (base_reg[BIT_MASTER_INT] && !base_reg[BIT_FORCE_INT] && !filt_int_req &&
     !(base_reg[BIT_DOWN_INT_EN] && down_zero) && !(base_reg[BIT_UP_INT_EN] && up_event))
      |=> !int_req)
    else $error("Interrupt stayed up with no cause after the force bit was cleared.");
  a_up_int: assert property (
    (base_reg[BIT_MASTER_INT] && base_reg[BIT_UP_INT_EN] && up_event) |=> int_req)
    else $error("Up-counter period event did not interrupt.");

  // Host port answers.
  a_ack_follows: assert property (##1 reg_ack == $past(reg_wr || reg_rd))
    else $error("Acknowledge not exactly one clock after a strobe.");
  a_base_writes: assert property (
    (reg_wr && hit(reg_addr, OFS_BASE)) |=> base_reg == $past(reg_wdata))
    else $error("Base control word did not store the written value.");
  a_ctrl_readback: assert property (
    (reg_rd && hit(reg_addr, OFS_CTRL_HIGH)) |=> reg_rdata == $past(ctrl_reg[47:32]))
    else $error("High control word read returned a wrong value.");
  a_unmapped_zero: assert property (
    (reg_rd && !hit(reg_addr, OFS_CTRL_LOW) && !hit(reg_addr, OFS_CTRL_MID) &&
     !hit(reg_addr, OFS_CTRL_HIGH) && !hit(reg_addr, OFS_BASE)) |=> reg_rdata == 16'h0000)
    else $error("Read of an unmapped offset did not return zero.");

  c_sync_enable: cover property ($rose(base_reg[BIT_OUT_REG_EN]) ##1 se_drive_low != '0);
  c_force_int: cover property (base_reg[BIT_FORCE_INT] ##1 int_req);
  c_up_int: cover property (base_reg[BIT_UP_INT_EN] && up_event ##1 int_req);
endmodule
`default_nettype wire

// ==== inc/pioc_pkg.sv ====
// Purpose: Shared constants for the parallel I/O output control block.
// Assumes: 16-bit host register port with byte offsets, one clock domain.
// Notes:   Offsets are byte addresses on the host register port.
package pioc_pkg;

  localparam int WORD_W      = 16;
  localparam int ADDR_W      = 7;
  localparam int NUM_LINES   = 48;
  localparam int MAX_PAIRS   = 24;
  localparam int CNT_W       = 32;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_CTRL_LOW  = 7'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_MID  = 7'h02;
  localparam logic [ADDR_W-1:0] OFS_CTRL_HIGH = 7'h04;
  localparam logic [ADDR_W-1:0] OFS_BASE      = 7'h06;

  // Values after reset.
  localparam logic [WORD_W-1:0] CTRL_RESET = 16'hffff;
  localparam logic [WORD_W-1:0] BASE_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 32'h0000_0000;

  // Base control word field positions.
  localparam int BIT_OUT_REG_EN  = 0;
  localparam int BIT_MASTER_INT  = 1;
  localparam int BIT_FORCE_INT   = 2;
  localparam int BIT_DOWN_INT_EN = 8;
  localparam int BIT_DOWN_LOAD   = 9;
  localparam int BIT_SQUARE_WAVE = 10;
  localparam int BIT_UP_INT_EN   = 12;
  localparam int BIT_UP_CLEAR    = 13;
  localparam int BIT_UP_HOLD     = 14;

endpackage

// ==== logic/pioc_down_counter.sv ====
// Purpose: Reload-on-zero down counter with zero pulse and square wave.
// Assumes: Preload value is stable or changes only between counts.
// Notes:   A preload of N gives a zero pulse every N+1 clocks.
`timescale 1ns/100ps
`default_nettype none
module pioc_down_counter (
  input  wire logic                      clock,        // Bus clock.
  input  wire logic                      rst_n,        // Synchronous reset, active low.
  input  wire logic                      load,         // Load preload while high.
  input  wire logic [pioc_pkg::CNT_W-1:0] preload,     // Reload value.
  output logic                           zero_pulse,   // One-cycle pulse at each zero.
  output logic                           wave          // Square wave, toggles at zero.
);
  import pioc_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             zero_reg;
  logic             zero_next;
  logic             wave_reg;
  logic             wave_next;

  always_comb begin
    count_next = count_reg - 32'h0000_0001;
    zero_next  = 1'b0;
    wave_next  = wave_reg;
    if (load) begin
      count_next = preload;
    end else if (count_reg == CNT_RESET) begin
      count_next = preload;
      zero_next  = 1'b1;
      wave_next  = ~wave_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= CNT_RESET;
      zero_reg  <= 1'b0;
      wave_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      zero_reg  <= zero_next;
      wave_reg  <= wave_next;
    end
  end

  assign zero_pulse = zero_reg;
  assign wave       = wave_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_load_takes_preload: assert property (load |=> count_reg == $past(preload))
    else $error("Down counter did not take the preload value while loading.");
  a_zero_reloads: assert property (
    (!load && count_reg == CNT_RESET) |=> (count_reg == $past(preload) && zero_reg))
    else $error("Down counter did not reload and pulse at zero.");
  a_wave_follows_zero: assert property (
    ##1 (zero_reg == (wave_reg != $past(wave_reg))))
    else $error("Square wave did not toggle exactly at a zero pulse.");
  c_zero_seen: cover property (!load ##1 zero_reg);
endmodule
`default_nettype wire

// ==== logic/pioc_up_counter.sv ====
// Purpose: Free-running up counter with masked period event and readback.
// Assumes: Mask selects one or more count bits for the event period.
// Notes:   The event fires when the masked count turns from zero to nonzero.
`timescale 1ns/100ps
`default_nettype none
module pioc_up_counter (
  input  wire logic                       clock,     // Bus clock.
  input  wire logic                       rst_n,     // Synchronous reset, active low.
  input  wire logic                       clear,     // Force count to zero while high.
  input  wire logic                       hold,      // Freeze the readback while high.
  input  wire logic [pioc_pkg::CNT_W-1:0] mask,      // Period select mask.
  output logic                            event_pulse, // One-cycle period event.
  output logic [pioc_pkg::CNT_W-1:0]      readback   // Readback copy of the count.
);
  import pioc_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] rdbk_reg;
  logic [CNT_W-1:0] rdbk_next;
  logic             hit_reg;
  logic             hit_next;
  logic             event_reg;
  logic             event_next;

  always_comb begin
    count_next = clear ? CNT_RESET : count_reg + 32'h0000_0001;
    rdbk_next  = hold ? rdbk_reg : count_reg;
    hit_next   = |(count_reg & mask);
    event_next = hit_next & ~hit_reg;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= CNT_RESET;
      rdbk_reg  <= CNT_RESET;
      hit_reg   <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      rdbk_reg  <= rdbk_next;
      hit_reg   <= hit_next;
      event_reg <= event_next;
    end
  end

  assign event_pulse = event_reg;
  assign readback    = rdbk_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_clear_zeroes: assert property (clear |=> count_reg == CNT_RESET)
    else $error("Up counter not zero after clear.");
  a_hold_freezes: assert property (
    (hold && !clear) |=> $stable(rdbk_reg) && count_reg != $past(count_reg))
    else $error("Readback moved or counter stopped during hold.");
  a_run_counts: assert property (!clear |=> count_reg == $past(count_reg) + 32'h0000_0001)
    else $error("Up counter did not advance while running.");
  c_up_event: cover property (event_reg);
endmodule
`default_nettype wire

// ==== verif/pioc_host_model.sv ====
// Purpose: Host side of the register port, issuing one-cycle strobes.
// Assumes: A strobe is taken on a rising edge and acknowledged one clock later.
// Notes:   Idle address and data lines show the inverse of their last value.
`timescale 1ns/100ps
`default_nettype none
module pioc_host_model (
  input  wire logic                        clock,     // Bus clock.
  input  wire logic                        reg_ack,   // Access done.
  input  wire logic [pioc_pkg::WORD_W-1:0] reg_rdata, // Read data.
  output logic      [pioc_pkg::ADDR_W-1:0] reg_addr,  // Byte offset.
  output logic                             reg_wr,    // Write strobe.
  output logic                             reg_rd,    // Read strobe.
  output logic      [pioc_pkg::WORD_W-1:0] reg_wdata  // Write data.
);
  import pioc_pkg::*;
  initial begin
    reg_addr = 7'h7f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // The strobe stands one cycle; the ack and read data are taken after the next edge.
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                        output logic [WORD_W-1:0] q, output logic k);
    @(posedge clock);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    k = reg_ack;
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the output control block in all seven variants.
// Assumes: One host model drives the shared register port of every variant.
// Notes:   Register answers are taken from the all single-ended variant.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pioc_pkg::*;
  localparam int PAIRS [7] = '{0, 4, 8, 12, 16, 20, 24};
  localparam logic [47:0] W1 = 48'h5a3c_9617_e28d;
  localparam logic [47:0] W2 = 48'ha5c3_69e8_1d72;
  localparam logic [47:0] W3 = 48'ha5c3_0ff0_1d72;
  logic                   clock;
  logic                   rst_n;
  logic                   filt;
  logic [31:0]            preload;
  logic [31:0]            mask;
  logic [ADDR_W-1:0]      addr;
  logic                   wr_s;
  logic                   rd_s;
  logic [WORD_W-1:0]      wdata;
  logic [6:0][WORD_W-1:0] rdat;
  logic [6:0]             ack;
  logic [6:0]             irq;
  logic [6:0][47:0]       se_low;
  logic [6:0][23:0]       dd;
  logic [6:0][23:0]       dt;
  logic [6:0][31:0]       rb;
  int                     fail_count;
  int                     n_compared;
  int                     cycles = 0;

  pioc_host_model i_host (.clock(clock), .reg_ack(ack[0]), .reg_rdata(rdat[0]),
    .reg_addr(addr), .reg_wr(wr_s), .reg_rd(rd_s), .reg_wdata(wdata));

  for (genvar v = 0; v < 7; v++) begin : g_var
    pioc_output_control #(.DIFF_PAIRS(PAIRS[v])) i_dut (.clock(clock), .rst_n(rst_n),
      .reg_addr(addr), .reg_wr(wr_s), .reg_rd(rd_s), .reg_wdata(wdata),
      .reg_rdata(rdat[v]), .reg_ack(ack[v]), .preload_value(preload), .mask_value(mask),
      .filt_int_req(filt), .se_drive_low(se_low[v]), .diff_data(dd[v]), .diff_tx_en(dt[v]),
      .int_req(irq[v]), .up_readback(rb[v]));
  end

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic        k;
    i_host.access(1'b1, a, d, q, k);
    check(k, 1'b1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    logic [15:0] q;
    logic        k;
    i_host.access(1'b0, a, 16'h0000, q, k);
    check({k, q}, {1'b1, e});
  endtask

  task automatic put_words(input logic [47:0] w);
    wr(OFS_CTRL_LOW, w[15:0]);
    wr(OFS_CTRL_MID, w[31:16]);
    wr(OFS_CTRL_HIGH, w[47:32]);
  endtask

  // Works out every variant's lines from the three words and compares them.
  task automatic chk_map(input logic [47:0] w);
    logic [47:0] se;
    logic [23:0] dx;
    logic [23:0] tx;
    int          p;
    for (int v = 0; v < 7; v++) begin
      p = PAIRS[v];
      se = '0;
      dx = '0;
      tx = '0;
      for (int i = 0; i < 48 - 2 * p; i++) se[i] = ~w[i];
      for (int k = 0; k < p; k++) begin
        dx[k] = w[48 - 2 * p + k];
        tx[k] = w[48 - p + k];
      end
      check(se_low[v], se);
      check(dd[v], dx);
      check(dt[v], tx);
    end
  endtask

  // Cycles between two rises of the interrupt, or two toggles of line 47; -1 if none.
  task automatic gap(input logic wave, input int limit, output int g);
    logic prev;
    logic cur;
    int   n;
    int   first;
    n = 0;
    first = -1;
    g = -1;
    prev = wave ? se_low[0][47] : irq[0];
    while (n < limit && g < 0) begin
      wait_n(1);
      n++;
      cur = wave ? se_low[0][47] : irq[0];
      if (cur !== prev && (wave || cur === 1'b1)) begin
        if (first < 0) first = n;
        else g = n - first;
      end
      prev = cur;
    end
  endtask

  task automatic base_irq(input logic [15:0] b, input logic e);
    wr(OFS_BASE, b);
    wait_n(2);
    check(irq[0], e);
  endtask

  task automatic t_reset();
    for (int v = 0; v < 7; v++) begin
      check(se_low[v], '0);
      check(dt[v], '0);
    end
    rd(OFS_CTRL_LOW, 16'hffff);
    rd(OFS_CTRL_MID, 16'hffff);
    rd(OFS_CTRL_HIGH, 16'hffff);
    rd(OFS_BASE, 16'h0000);
    rd(7'h08, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_map();
    put_words(W1);
    wr(OFS_BASE, 16'h88f9);
    rd(OFS_BASE, 16'h88f9);
    rd(OFS_CTRL_LOW, W1[15:0]);
    rd(OFS_CTRL_MID, W1[31:16]);
    rd(OFS_CTRL_HIGH, W1[47:32]);
    chk_map(W1);
    $display("test map done");
  endtask

  task automatic t_hold();
    wr(OFS_BASE, 16'h0000);
    put_words(W2);
    wait_n(4);
    chk_map(W1);
    wr(OFS_BASE, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      check(se_low[0] === ~W1 || se_low[0] === ~W2, 1'b1);
      wait_n(1);
    end
    chk_map(W2);
    wr(OFS_CTRL_MID, W3[31:16]);
    wait_n(3);
    chk_map(W3);
    put_words(W1);
    wait_n(3);
    chk_map(W1);
    $display("test hold done");
  endtask

  task automatic t_int();
    base_irq(16'h0005, 1'b0);
    base_irq(16'h0007, 1'b1);
    base_irq(16'h0003, 1'b0);
    @(posedge clock);
    filt <= 1'b1;
    base_irq(16'h0003, 1'b1);
    base_irq(16'h0001, 1'b0);
    @(posedge clock);
    filt <= 1'b0;
    $display("test interrupt done");
  endtask

  task automatic t_down();
    int g;
    @(posedge clock);
    preload <= 32'h5;
    wr(OFS_BASE, 16'h0703);
    gap(1'b0, 30, g);
    check(g, -1);
    wr(OFS_BASE, 16'h0501);
    gap(1'b0, 30, g);
    check(g, -1);
    wr(OFS_BASE, 16'h0503);
    gap(1'b0, 60, g);
    check(g, 6);
    gap(1'b1, 60, g);
    check(g, 6);
    wr(OFS_BASE, 16'h0001);
    wait_n(3);
    check(se_low[0][47], {~W1[47]});
    $display("test down counter done");
  endtask

  task automatic t_up();
    int          g;
    logic [31:0] h;
    @(posedge clock);
    mask <= 32'h4;
    wr(OFS_BASE, 16'h3003);
    gap(1'b0, 30, g);
    check(g, -1);
    check(rb[0], 32'h0);
    wr(OFS_BASE, 16'h1003);
    gap(1'b0, 60, g);
    check(g, 8);
    wr(OFS_BASE, 16'h5003);
    wait_n(2);
    h = rb[0];
    wait_n(6);
    check(rb[0], h);
    wr(OFS_BASE, 16'h1003);
    wait_n(3);
    check(rb[0] > h + 32'd6, 1'b1);
    $display("test up counter done");
  endtask

  initial begin
    rst_n = 1'b0;
    filt = 1'b0;
    preload = 32'h0;
    mask = 32'h0;
    fail_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    wait_n(1);
    t_reset();
    t_map();
    t_hold();
    t_int();
    t_down();
    t_up();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    wait_n(1);
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
